// *** ubg_pkg.sv ***
/*
 * Shared constants of the asynchronous baud-rate generator: register
 * offsets, field positions, reset values and clock divide ratios.
 * Assumes a single core clock that stands in for the oscillator.
 */
package ubg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] ADDR_CLKCTRL = 8'h00;
    localparam logic [7:0] ADDR_TMRCTRL = 8'h04;
    localparam logic [7:0] ADDR_T1      = 8'h08;
    localparam logic [7:0] ADDR_T3      = 8'h0C;
    localparam logic [7:0] ADDR_T2CNT   = 8'h10;
    localparam logic [7:0] ADDR_T2RLD   = 8'h14;
    localparam logic [7:0] ADDR_STATUS  = 8'h18;

    ////////////////////////////////////////////////////////////////////////
    // Clock control register fields and reset value (default 4 cycles).
    localparam int          CC_MULT    = 0;
    localparam int          CC_DIV     = 1;
    localparam int          CC_T1SEL   = 3;
    localparam int          CC_T3SEL   = 4;
    localparam int          CC_TXT2    = 5;
    localparam int          CC_RXT2    = 6;
    localparam int          CC_DBL     = 7;
    localparam int          CC_W       = 10;
    localparam logic [9:0]  CC_RST     = 10'h002;

    // Timer control register fields and reset value.
    localparam int          TC_T1MODE  = 0;
    localparam int          TC_T1CNT   = 2;
    localparam int          TC_T1RUN   = 3;
    localparam int          TC_T3MODE  = 4;
    localparam int          TC_T3CNT   = 6;
    localparam int          TC_T3RUN   = 7;
    localparam int          TC_T2RUN   = 8;
    localparam int          TC_T2EXEN  = 9;
    localparam int          TC_T2IE    = 10;
    localparam int          TC_W       = 11;
    localparam logic [10:0] TC_RST     = 11'h000;

    // Status register flag positions.
    localparam int          ST_T2OVF   = 0;
    localparam int          ST_T1OVF   = 1;
    localparam int          ST_T3OVF   = 2;

    ////////////////////////////////////////////////////////////////////////
    // Divide ratios, in oscillator (core clock) cycles.
    localparam int          DIV_TSLOW  = 12;
    localparam int          DIV_PMMLO  = 3072;
    localparam int          DIV_PMM    = 1024;
    localparam int          DIV_T2BAUD = 2;
    localparam int          MC_4X      = 1;
    localparam int          MC_2X      = 2;
    localparam int          MC_DEF     = 4;
    localparam logic [11:0] PRE_LAST   = 12'hBFF;
    localparam logic [4:0]  BAUD_SLOW  = 5'h1F;
    localparam logic [4:0]  BAUD_FAST  = 5'h0F;

    // Timer operating modes of the 8-bit timers.
    typedef enum logic [1:0] {
        UBG_TM_13BIT,
        UBG_TM_16BIT,
        UBG_TM_AUTO8,
        UBG_TM_HOLD
    } ubg_tmode_type;

endpackage

// *** ubg_tick_if.sv ***
/*
 * Link between the timer section and one baud divider: overflow pulse,
 * divide-by-16 select and the resulting bit-clock pulse.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/100ps
interface ubg_tick_if;
    logic ovf;   // One-cycle timer overflow pulse.
    logic by16;  // High divides by 16, low by 32.
    logic tick;  // One-cycle bit-clock pulse.

    modport src (output ovf, output by16, input tick);
    modport div (input ovf, input by16, output tick);
endinterface

// *** ubg_baud_div.sv ***
/*
 * Baud divider: counts timer overflow pulses and gives one bit-clock
 * pulse every 16 or 32 of them.
 * Assumes overflow pulses last exactly one core clock cycle.
 */
`timescale 1ns/100ps
module ubg_baud_div #(
    parameter int CNT_W = 5                // Divider counter width.
) (
    input  wire logic clk,                 // Core clock.
    input  wire logic rst_n,               // Synchronous reset, active low.
    ubg_tick_if.div   lnk                  // Overflow in, bit clock out.
);

    if (CNT_W != 5) begin : g_bad_width
        $error("ubg_baud_div: CNT_W must be 5");
    end

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             tick_ff;
    logic [CNT_W-1:0] limit;
    logic             wrap;

    ////////////////////////////////////////////////////////////////////////
    // Terminal count follows the doubler; a count already beyond the new
    // limit wraps on the next overflow so a doubler change never stalls the divider.
    assign limit   = lnk.by16 ? ubg_pkg::BAUD_FAST : ubg_pkg::BAUD_SLOW;
    assign wrap    = lnk.ovf && (cnt_ff >= limit);
    assign nxt_cnt = wrap ? '0 : cnt_ff + CNT_W'(lnk.ovf);

    // Counter and registered bit-clock pulse.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= wrap;
        end
    end

    assign lnk.tick = tick_ff;

    ////////////////////////////////////////////////////////////////////////
    // A pulse only ever follows an overflow that hit the terminal count.
    chk_div_cause: assert property (@(posedge clk) disable iff (!rst_n)
        lnk.tick |-> $past(lnk.ovf) && ($past(cnt_ff) >= $past(limit)))
        else $error("bit clock without terminal overflow");

    // Each overflow below the terminal count advances the count by exactly one.
    chk_div_step: assert property (@(posedge clk) disable iff (!rst_n)
        lnk.ovf && (cnt_ff < limit) |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("overflow not counted once");

endmodule

// *** ubg_baud_gen.sv ***
/*
 * Baud-rate generator for the asynchronous modes of three serial ports:
 * timers 1, 2 and 3 with their input clock selection, and four baud
 * dividers. Registers sit on an AHB-Lite slave with zero wait states.
 * Assumes synchronous pin inputs and a core clock equal to the oscillator.
 */
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module ubg_baud_gen (
    input  wire logic        CORE_CLK,               // Core clock, 100 MHz.
    input  wire logic        RSTN,                   // Synchronous reset, low.
    input  wire logic        HSEL,                   // Slave select.
    input  wire logic [31:0] HADDR,                  // Byte address.
    input  wire logic [1:0]  HTRANS,                 // Transfer type.
    input  wire logic        HWRITE,                 // Write when high.
    input  wire logic [2:0]  HSIZE,                  // Transfer size.
    input  wire logic [31:0] HWDATA,                 // Write data.
    input  wire logic        HREADY,                 // Bus ready.
    output logic      [31:0] HRDATA,                 // Read data.
    output logic             HREADYOUT,              // Always ready.
    output logic             HRESP,                  // Always OKAY.
    input  wire logic        T1_COUNT_PIN,           // Timer 1 count input.
    input  wire logic        T3_COUNT_PIN,           // Timer 3 count input.
    input  wire logic        TIMER2_EXT_RELOAD_PIN,  // Timer 2 reload input.
    output logic             BAUD_TX0,               // Port 0 transmit tick.
    output logic             BAUD_RX0,               // Port 0 receive tick.
    output logic             BAUD_PORT1,             // Port 1 tick.
    output logic             BAUD_PORT2,             // Port 2 tick.
    output logic             TIMER2_IRQ              // Timer 2 interrupt.
);

    ////////////////////////////////////////////////////////////////////////
    // One step of an 8-bit style timer; bit 16 is the overflow.
    function automatic logic [16:0] ubg_t8_step(input logic [15:0] c,
                                                input logic [1:0]  m);
        logic [12:0] v13;
        logic [16:0] r;
        v13 = {c[15:8], c[4:0]} + 13'h0001;
        r   = {1'b0, c};
        case (ubg_pkg::ubg_tmode_type'(m))
            ubg_pkg::UBG_TM_13BIT: r = {&{c[15:8], c[4:0]}, v13[12:5], c[7:5], v13[4:0]};
            ubg_pkg::UBG_TM_16BIT: r = {1'b0, c} + 17'h0_0001;
            ubg_pkg::UBG_TM_AUTO8: r = {&c[7:0], c[15:8],
                                        (&c[7:0]) ? c[15:8] : c[7:0] + 8'h01};
            default:               r = {1'b0, c};
        endcase
        return r;
    endfunction

    // Timer input divisor from power mode, select bit and machine ratio.
    function automatic int ubg_timer_div(input logic power_saving_clock_mode, input logic sel,
                                         input int mach);
        if (power_saving_clock_mode) begin
            return sel ? ubg_pkg::DIV_PMM : ubg_pkg::DIV_PMMLO;
        end
        return sel ? mach : ubg_pkg::DIV_TSLOW;
    endfunction

    // True on the last core cycle of each period of the given divisor.
    function automatic logic ubg_rate_hit(input logic [11:0] c, input int d);
        return (int'(c) % d) == (d - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [ubg_pkg::CC_W-1:0] clkctrl_ff;
    logic [ubg_pkg::TC_W-1:0] tmrctrl_ff;
    logic [15:0]              t13_cnt_ff [2];
    logic [15:0]              nxt_t13_cnt [2];
    logic [15:0]              t2_cnt_ff;
    logic [15:0]              nxt_t2_cnt;
    logic [15:0]              t2_rld_ff;
    logic [2:0]               status_ff;
    logic [2:0]               nxt_status;
    logic [11:0]              pre_ff;
    logic [2:0]               pin_ff;
    logic                     wr_pend_ff;
    logic [7:0]               wr_addr_ff;
    logic [31:0]              hrdata_ff;
    logic [31:0]              rd_mux;
    logic                     power_saving_clock_mode;
    int                       mach;
    logic                     t2_baud;
    logic [1:0]               t13_rate;
    logic [1:0]               t13_fall;
    logic [1:0]               t13_inc;
    logic [1:0]               t13_ovf;
    logic [1:0]               t13_mode [2];
    logic [16:0]              t13_step [2];
    logic                     t2_rate;
    logic                     t2_inc;
    logic                     t2_ovf;
    logic                     t2_ext;
    logic                     addr_ok;
    logic                     wr_en;
    logic [2:0]               dbl;
    logic [2:0]               w1c;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: no wait states, always OKAY. Read data is sampled at
    // the address phase; writes land at the end of the data phase.
    assign addr_ok   = HSEL && HTRANS[1] && HREADY && (HADDR[31:8] == 24'h00_0000);
    assign wr_en     = wr_pend_ff;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = hrdata_ff;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff  <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= addr_ok && HWRITE;
            wr_addr_ff <= HADDR[7:0];
            hrdata_ff  <= (addr_ok && !HWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        case (HADDR[7:0])
            ubg_pkg::ADDR_CLKCTRL: rd_mux = 32'(clkctrl_ff);
            ubg_pkg::ADDR_TMRCTRL: rd_mux = 32'(tmrctrl_ff);
            ubg_pkg::ADDR_T1:      rd_mux = 32'(t13_cnt_ff[0]);
            ubg_pkg::ADDR_T3:      rd_mux = 32'(t13_cnt_ff[1]);
            ubg_pkg::ADDR_T2CNT:   rd_mux = 32'(t2_cnt_ff);
            ubg_pkg::ADDR_T2RLD:   rd_mux = 32'(t2_rld_ff);
            ubg_pkg::ADDR_STATUS:  rd_mux = 32'(status_ff);
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock mode decode: 100 gives 1 cycle, 000 gives 2, X11 power mode.
    assign power_saving_clock_mode  = clkctrl_ff[ubg_pkg::CC_DIV +: 2] == 2'b11;
    assign mach = (clkctrl_ff[ubg_pkg::CC_DIV +: 2] != 2'b00) ? ubg_pkg::MC_DEF :
                  clkctrl_ff[ubg_pkg::CC_MULT] ? ubg_pkg::MC_4X : ubg_pkg::MC_2X;
    assign t2_baud = clkctrl_ff[ubg_pkg::CC_TXT2] || clkctrl_ff[ubg_pkg::CC_RXT2];
    assign dbl     = clkctrl_ff[ubg_pkg::CC_DBL +: 3];

    // Input rate enables from one free prescaler; 3072 is a multiple of
    // every ratio, so all enables stay evenly spaced across its wrap.
    assign t13_rate[0] = ubg_rate_hit(pre_ff, ubg_timer_div(power_saving_clock_mode,
                             clkctrl_ff[ubg_pkg::CC_T1SEL], mach));
    assign t13_rate[1] = ubg_rate_hit(pre_ff, ubg_timer_div(power_saving_clock_mode,
                             clkctrl_ff[ubg_pkg::CC_T3SEL], mach));
    assign t2_rate = t2_baud ? ubg_rate_hit(pre_ff,
                                 power_saving_clock_mode ? ubg_pkg::DIV_PMM : ubg_pkg::DIV_T2BAUD)
                             : ubg_rate_hit(pre_ff, ubg_timer_div(power_saving_clock_mode, 1'b0, mach));

    // Counter inputs count falling edges of the pins.
    assign t13_fall = pin_ff[1:0] & ~{T3_COUNT_PIN, T1_COUNT_PIN};
    assign t2_ext   = pin_ff[2] && !TIMER2_EXT_RELOAD_PIN
                      && tmrctrl_ff[ubg_pkg::TC_T2EXEN] && !t2_baud;

    assign t13_mode[0] = tmrctrl_ff[ubg_pkg::TC_T1MODE +: 2];
    assign t13_mode[1] = tmrctrl_ff[ubg_pkg::TC_T3MODE +: 2];
    assign t13_inc[0]  = tmrctrl_ff[ubg_pkg::TC_T1RUN] &&
                         (tmrctrl_ff[ubg_pkg::TC_T1CNT] ? t13_fall[0] : t13_rate[0]);
    assign t13_inc[1]  = tmrctrl_ff[ubg_pkg::TC_T3RUN] &&
                         (tmrctrl_ff[ubg_pkg::TC_T3CNT] ? t13_fall[1] : t13_rate[1]);
    assign t2_inc      = tmrctrl_ff[ubg_pkg::TC_T2RUN] && t2_rate;

    ////////////////////////////////////////////////////////////////////////
    // Timers 1 and 3 share one step function; a bus write beats a count.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            t13_step[i]    = ubg_t8_step(t13_cnt_ff[i], t13_mode[i]);
            t13_ovf[i]     = t13_inc[i] && t13_step[i][16];
            nxt_t13_cnt[i] = t13_inc[i] ? t13_step[i][15:0] : t13_cnt_ff[i];
        end
        if (wr_en && wr_addr_ff == ubg_pkg::ADDR_T1) begin
            nxt_t13_cnt[0] = HWDATA[15:0];
        end
        if (wr_en && wr_addr_ff == ubg_pkg::ADDR_T3) begin
            nxt_t13_cnt[1] = HWDATA[15:0];
        end
    end

    // Timer 2: 16-bit count reloading from the reload pair on rollover.
    assign t2_ovf = t2_inc && (t2_cnt_ff == 16'hFFFF);
    always_comb begin
        nxt_t2_cnt = t2_cnt_ff;
        if (wr_en && wr_addr_ff == ubg_pkg::ADDR_T2CNT) begin
            nxt_t2_cnt = HWDATA[15:0];
        end else if (t2_ovf || t2_ext) begin
            nxt_t2_cnt = t2_rld_ff;
        end else if (t2_inc) begin
            nxt_t2_cnt = t2_cnt_ff + 16'h0001;
        end
    end

    // Sticky flags: write one to clear, a new overflow wins over the clear.
    assign w1c = (wr_en && wr_addr_ff == ubg_pkg::ADDR_STATUS) ? HWDATA[2:0] : 3'h0;
    assign nxt_status = (status_ff & ~w1c)
                      | {t13_ovf[1], t13_ovf[0], t2_ovf && !t2_baud};
    assign TIMER2_IRQ = status_ff[ubg_pkg::ST_T2OVF]
                      && tmrctrl_ff[ubg_pkg::TC_T2IE] && !t2_baud;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers; reset clears every doubler bit.
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            clkctrl_ff <= ubg_pkg::CC_RST;
            tmrctrl_ff <= ubg_pkg::TC_RST;
            t2_rld_ff  <= 16'h0000;
        end else if (wr_en) begin
            if (wr_addr_ff == ubg_pkg::ADDR_CLKCTRL) begin
                clkctrl_ff <= HWDATA[ubg_pkg::CC_W-1:0];
            end
            if (wr_addr_ff == ubg_pkg::ADDR_TMRCTRL) begin
                tmrctrl_ff <= HWDATA[ubg_pkg::TC_W-1:0];
            end
            if (wr_addr_ff == ubg_pkg::ADDR_T2RLD) begin
                t2_rld_ff <= HWDATA[15:0];
            end
        end
    end

    // Counters, flags, prescaler and pin history.
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            t13_cnt_ff <= '{16'h0000, 16'h0000};
            t2_cnt_ff  <= 16'h0000;
            status_ff  <= 3'h0;
            pre_ff     <= 12'h000;
            pin_ff     <= 3'h0;
        end else begin
            t13_cnt_ff <= nxt_t13_cnt;
            t2_cnt_ff  <= nxt_t2_cnt;
            status_ff  <= nxt_status;
            pre_ff     <= (pre_ff == ubg_pkg::PRE_LAST) ? 12'h000 : pre_ff + 12'h001;
            pin_ff     <= {TIMER2_EXT_RELOAD_PIN, T3_COUNT_PIN, T1_COUNT_PIN};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Baud source steering: port 0 picks per direction, ports 1 and 2 fixed.
    ubg_tick_if lnk [4] ();

    assign lnk[0].ovf  = clkctrl_ff[ubg_pkg::CC_TXT2] ? t2_ovf : t13_ovf[0];
    assign lnk[0].by16 = clkctrl_ff[ubg_pkg::CC_TXT2] || dbl[0];
    assign lnk[1].ovf  = clkctrl_ff[ubg_pkg::CC_RXT2] ? t2_ovf : t13_ovf[0];
    assign lnk[1].by16 = clkctrl_ff[ubg_pkg::CC_RXT2] || dbl[0];
    assign lnk[2].ovf  = t13_ovf[0];
    assign lnk[2].by16 = dbl[1];
    assign lnk[3].ovf  = t13_ovf[1];
    assign lnk[3].by16 = dbl[2];

    for (genvar k = 0; k < 4; k++) begin : g_div
        ubg_baud_div #(.CNT_W(5)) u_div (
            .clk   (CORE_CLK),
            .rst_n (RSTN),
            .lnk   (lnk[k].div)
        );
    end

    assign BAUD_TX0   = lnk[0].tick;
    assign BAUD_RX0   = lnk[1].tick;
    assign BAUD_PORT1 = lnk[2].tick;
    assign BAUD_PORT2 = lnk[3].tick;

    ////////////////////////////////////////////////////////////////////////
    chk_t2_flag_quiet: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        t2_baud && t2_ovf |=> !$rose(status_ff[ubg_pkg::ST_T2OVF]) && !(t2_baud && TIMER2_IRQ))
        else $error("timer 2 flag set in baud mode");

    chk_t1_autoreload: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        t13_inc[0] && t13_mode[0] == 2'b10 && t13_cnt_ff[0][7:0] == 8'hFF && !wr_en
        |=> t13_cnt_ff[0][7:0] == $past(t13_cnt_ff[0][15:8]))
        else $error("timer 1 did not reload from high byte");

    chk_t2_reload: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        t2_inc && t2_cnt_ff == 16'hFFFF && !wr_en |=> t2_cnt_ff == $past(t2_rld_ff))
        else $error("timer 2 did not reload on rollover");

    chk_t2_no_ext: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        t2_baud && pin_ff[2] && !TIMER2_EXT_RELOAD_PIN && !t2_inc && !wr_en
        |=> $stable(t2_cnt_ff))
        else $error("external reload acted in baud mode");

    chk_t2_half_rate: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (t2_baud && !power_saving_clock_mode && t2_rate && !wr_en) ##1 !wr_en |-> !t2_rate ##1 t2_rate)
        else $error("timer 2 baud input not oscillator over 2");

    // A write inside the twelve cycles may legally change the rate, so none may occur.
    chk_t1_div12: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (!power_saving_clock_mode && !clkctrl_ff[ubg_pkg::CC_T1SEL] && t13_rate[0] && !wr_en)
        ##1 !wr_en [*8] ##1 !wr_en [*3] |=> t13_rate[0])
        else $error("timer 1 input not over 12");

    chk_tx0_source: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        BAUD_TX0 && $past(clkctrl_ff[ubg_pkg::CC_TXT2]) |-> $past(t2_ovf))
        else $error("transmit tick not from timer 2");

    chk_dbl_reset: assert property (@(posedge CORE_CLK)
        !RSTN |=> dbl == 3'b000)
        else $error("doubler not cleared by reset");

endmodule

// *** tb_top.sv ***
/* Testbench of the baud-rate generator: registers set over AHB-Lite, bit-clock periods measured.
   Assumes the zero-wait slave and register map that the package describes. */
`timescale 1ns/100ps
module tb_top;
    typedef struct {logic [9:0] cc; logic [7:0] a; logic [15:0] v; int o; int p;} ubg_row_type;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hi = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        pin = 1'b0;
    wire  [31:0] hrdata;
    wire         hready;
    wire  [3:0]  baud;
    wire         irq;
    wire         hresp;
    logic [31:0] rd;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          n;
    // Configuration, source register, output index and expected period in cycles.
    ubg_row_type rows [10] = '{'{10'h009, 8'h08, 16'hFEFE, 2, 64}, '{10'h109, 8'h08, 16'hFEFE, 2, 32},
        '{10'h001, 8'h08, 16'hFFFF, 2, 384}, '{10'h00B, 8'h08, 16'hFFFF, 2, 128},
        '{10'h008, 8'h08, 16'hFFFF, 2, 64}, '{10'h019, 8'h0C, 16'hFCFC, 3, 128},
        '{10'h219, 8'h0C, 16'hFCFC, 3, 64}, '{10'h029, 8'h14, 16'hFFFE, 0, 64},
        '{10'h029, 8'h08, 16'hFDFD, 1, 96}, '{10'h049, 8'h14, 16'hFFFC, 1, 128}};

    ubg_baud_gen u_dut (.CORE_CLK(clk), .RSTN(rstn), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .T1_COUNT_PIN(pin), .T3_COUNT_PIN(pin),
        .TIMER2_EXT_RELOAD_PIN(pin), .BAUD_TX0(baud[0]), .BAUD_RX0(baud[1]),
        .BAUD_PORT1(baud[2]), .BAUD_PORT2(baud[3]), .TIMER2_IRQ(irq));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, pin toggling and the hang guard; toggling pins must not disturb timing.
    always #5 clk = ~clk;
    always @(posedge clk) pin <= ~pin;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            error_cnt++;
            complete_run();
        end
    end

    task complete_run();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One single transfer; the address phase stands until ready, then the data phase.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {23'h00_0000, hi, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // Counts cycles up to the next bit-clock pulse on output o.
    task pulse(input int o);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (baud[o] !== 1'b1 && n < 5000);
    endtask

    // Timer count gained between two reads whose address phases lie 3072 cycles apart.
    task span(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000);
        n = int'(rd);
        repeat (3069) @(posedge clk);
        bus(1'b0, a, 32'h0000_0000);
        n = int'(rd) - n;
    endtask

    task reset_dut();
        rstn <= 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Table of rates first, then flags, an unmapped place and a reset in mid-run.
    initial begin
        reset_dut();
        bus(1'b0, ubg_pkg::ADDR_CLKCTRL, 32'h0000_0000);
        check("clkctrl reset", rd, 32'h0000_0002);
        bus(1'b1, ubg_pkg::ADDR_TMRCTRL, 32'h0000_07AA);
        foreach (rows[i]) begin
            bus(1'b1, ubg_pkg::ADDR_CLKCTRL, {22'h00_0000, rows[i].cc});
            bus(1'b1, rows[i].a, {16'h0000, rows[i].v});
            if (rows[i].a == ubg_pkg::ADDR_T2RLD)
                bus(1'b1, ubg_pkg::ADDR_T2CNT, {16'h0000, rows[i].v});
            pulse(rows[i].o);
            pulse(rows[i].o);
            check("period", n, rows[i].p);
        end
        bus(1'b0, ubg_pkg::ADDR_STATUS, 32'h0000_0000);
        check("t2 flag", {31'h0000_0000, rd[0]}, 32'h0000_0000);
        check("t2 irq", {31'h0000_0000, irq}, 32'h0000_0000);
        hi = 1'b1;
        bus(1'b0, ubg_pkg::ADDR_CLKCTRL, 32'h0000_0000);
        hi = 1'b0;
        check("unmapped", rd, 32'h0000_0000);
        check("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
        // Power mode rates, counted as timer increments over one prescaler wrap.
        bus(1'b1, ubg_pkg::ADDR_CLKCTRL, 32'h0000_000E);
        bus(1'b1, ubg_pkg::ADDR_T1, 32'h0000_0000);
        span(ubg_pkg::ADDR_T1);
        check("pmm t1 fast", n, 3);
        bus(1'b1, ubg_pkg::ADDR_CLKCTRL, 32'h0000_0006);
        span(ubg_pkg::ADDR_T1);
        check("pmm t1 slow", n, 1);
        bus(1'b1, ubg_pkg::ADDR_CLKCTRL, 32'h0000_0026);
        bus(1'b1, ubg_pkg::ADDR_T2CNT, 32'h0000_0000);
        span(ubg_pkg::ADDR_T2CNT);
        check("pmm t2", n, 3);
        // Timer 1 as a counter of pin falling edges still feeds port 1.
        bus(1'b1, ubg_pkg::ADDR_TMRCTRL, 32'h0000_07AE);
        bus(1'b1, ubg_pkg::ADDR_T1, 32'h0000_FFFF);
        pulse(2);
        pulse(2);
        check("counter", n, 64);
        bus(1'b1, ubg_pkg::ADDR_CLKCTRL, 32'h0000_03C9);
        reset_dut();
        bus(1'b0, ubg_pkg::ADDR_CLKCTRL, 32'h0000_0000);
        check("doublers", rd, 32'h0000_0002);
        complete_run();
    end
endmodule
